// ### src/timer_pkg.sv
// shared constants for the event / pulse width timer
package timer_pkg;
    // counter widths
    localparam int CNT_W      = 8;
    localparam int DIV_W      = 5;
    // count source select codes for pulse width mode
    localparam logic [2:0] SRC_F1   = 3'h0;
    localparam logic [2:0] SRC_F2   = 3'h1;
    localparam logic [2:0] SRC_F8   = 3'h2;
    localparam logic [2:0] SRC_OCO  = 3'h3;
    localparam logic [2:0] SRC_C32  = 3'h4;
    // filter select codes
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [1:0] FILT_F1  = 2'h1;
    localparam logic [1:0] FILT_F8  = 2'h2;
    localparam logic [1:0] FILT_F32 = 2'h3;
    // divider taps: all low bits set marks one slow period
    localparam logic [DIV_W-1:0] DIV2_MASK  = 5'h01;
    localparam logic [DIV_W-1:0] DIV8_MASK  = 5'h07;
    localparam logic [DIV_W-1:0] DIV32_MASK = 5'h1F;
    // equal samples the filter needs before it moves
    localparam int FILT_SAMPLES = 3;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 8'hFF;
    // operating modes handled by this block
    typedef enum logic {MODE_EVENT, MODE_PULSE_WIDTH} mode_t;
    // run state of the counter chain
    typedef enum logic {ST_STOPPED, ST_RUNNING} run_state_t;
endpackage

// ### src/input_filter.sv
// digital noise filter: output follows input after equal consecutive samples
module input_filter #(
    parameter int SAMPLES = timer_pkg::FILT_SAMPLES
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // sampling
    input  wire logic sampleEn,
    input  wire logic din,
    output logic      dout
);
    // sample history, newest in bit 0
    logic [SAMPLES-1:0] hist_q;

    // shift in a sample on each sampling pulse
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hist_q <= '0;
        end else if (sampleEn) begin
            hist_q <= {hist_q[SAMPLES-2:0], din};
        end
    end

    // move output only when every stored sample agrees
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dout <= 1'b0;
        end else if (&hist_q) begin
            dout <= 1'b1;
        end else if (~|hist_q) begin
            dout <= 1'b0;
        end
    end
endmodule

// ### src/timer_event_pw.sv
// prescaler plus reload timer: event counter and pulse width measurement modes
module timer_event_pw #(
    parameter int CNT_W = timer_pkg::CNT_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // external pins and foreign clocks
    input  wire logic             ioPinA,
    input  wire logic             ioPinB,
    input  wire logic             onchipOscClock,
    input  wire logic             subclockDiv32,
    // count start / forced stop strobes
    input  wire logic             startWrite,
    input  wire logic             countStartBit,
    input  wire logic             forcedStopBit,
    // counter writes
    input  wire logic             preWrite,
    input  wire logic             timWrite,
    input  wire logic [CNT_W-1:0] wrData,
    // mode register write and configuration
    input  wire logic             modeWrite,
    input  wire logic             modeSelect,
    input  wire logic [2:0]       sourceSelect,
    input  wire logic             polaritySelectBit,
    input  wire logic             inputPinSelectBit,
    input  wire logic             invOutputEnableBit,
    input  wire logic             filterSelectBit0,
    input  wire logic             filterSelectBit1,
    // status and counts
    output logic [CNT_W-1:0]      prescalerCount,
    output logic [CNT_W-1:0]      timerCount,
    output logic                  countActive,
    // events and pins
    output logic                  timerIrq,
    output logic                  extIrqOne,
    output logic                  invertedOut,
    output logic                  invertedOutTimer
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    // one countdown step: {underflow, next value}
    function automatic logic [CNT_W:0] stepDown(input logic [CNT_W-1:0] cnt,
                                                input logic [CNT_W-1:0] rld);
        return (cnt == '0) ? {1'b1, rld} : {1'b0, cnt - CNT_W'(1)};
    endfunction
    // edge detect: rising when fall is low, falling otherwise
    function automatic logic edgeSeen(input logic prev, input logic cur,
                                      input logic fall);
        return fall ? (prev & ~cur) : (~prev & cur);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // two stages per foreign input; only stage two is read
    logic [1:0] pinA_q;          // pin a synchroniser
    logic [1:0] pinB_q;          // pin b synchroniser
    logic [1:0] oco_q;           // on-chip oscillator synchroniser
    logic [1:0] c32_q;           // subclock synchroniser
    logic       ocoPrev_q;       // oscillator edge history
    logic       c32Prev_q;       // subclock edge history

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinA_q    <= 2'h0;
            pinB_q    <= 2'h0;
            oco_q     <= 2'h0;
            c32_q     <= 2'h0;
            ocoPrev_q <= 1'b0;
            c32Prev_q <= 1'b0;
        end else begin
            pinA_q    <= {pinA_q[0], ioPinA};
            pinB_q    <= {pinB_q[0], ioPinB};
            oco_q     <= {oco_q[0], onchipOscClock};
            c32_q     <= {c32_q[0], subclockDiv32};
            ocoPrev_q <= oco_q[1];
            c32Prev_q <= c32_q[1];
        end
    end
    logic pinSel;
    assign pinSel = inputPinSelectBit ? pinB_q[1] : pinA_q[1];
    ////////////////////////////////////////////////////////////////////////
    // internal clock divider
    logic [timer_pkg::DIV_W-1:0] div_q;   // free-running divide counter
    // divider feeding the slow enables
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + timer_pkg::DIV_W'(1);
        end
    end
    logic tickF2, tickF8, tickF32, tickOco, tickC32;
    assign tickF2  = (div_q & timer_pkg::DIV2_MASK)  == timer_pkg::DIV2_MASK;
    assign tickF8  = (div_q & timer_pkg::DIV8_MASK)  == timer_pkg::DIV8_MASK;
    assign tickF32 = (div_q & timer_pkg::DIV32_MASK) == timer_pkg::DIV32_MASK;
    assign tickOco = edgeSeen(ocoPrev_q, oco_q[1], 1'b0);
    assign tickC32 = edgeSeen(c32Prev_q, c32_q[1], 1'b0);
    ////////////////////////////////////////////////////////////////////////
    // digital filter
    logic [1:0] filtSel;
    logic       filtSample;
    logic       filtOut;
    logic       measIn;          // synchronised, optionally filtered input
    logic       measPrev_q;      // previous measured level
    assign filtSel = {filterSelectBit1, filterSelectBit0};
    always_comb begin
        case (filtSel)
            timer_pkg::FILT_F1:  filtSample = 1'b1;
            timer_pkg::FILT_F8:  filtSample = tickF8;
            timer_pkg::FILT_F32: filtSample = tickF32;
            default:             filtSample = 1'b0;
        endcase
    end
    input_filter #(
        .SAMPLES (timer_pkg::FILT_SAMPLES)
    ) input_filter_inst (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .sampleEn (filtSample),
        .din      (pinSel),
        .dout     (filtOut)
    );
    assign measIn = (filtSel == timer_pkg::FILT_OFF) ? pinSel : filtOut;
    // level history for edge detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            measPrev_q <= 1'b0;
        end else begin
            measPrev_q <= measIn;
        end
    end
    // input doubles as external interrupt line
    assign extIrqOne = measIn;
    ////////////////////////////////////////////////////////////////////////
    // run control
    timer_pkg::run_state_t runState_q;
    timer_pkg::mode_t      mode;
    assign mode = timer_pkg::mode_t'(modeSelect);
    // start, stop and forced stop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            runState_q <= timer_pkg::ST_STOPPED;
        end else if (startWrite && forcedStopBit) begin
            runState_q <= timer_pkg::ST_STOPPED;
        end else if (startWrite) begin
            runState_q <= countStartBit ? timer_pkg::ST_RUNNING
                                        : timer_pkg::ST_STOPPED;
        end
    end
    logic running;
    assign running     = (runState_q == timer_pkg::ST_RUNNING);
    assign countActive = running;
    ////////////////////////////////////////////////////////////////////////
    // count source
    logic srcTick;     // selected internal clock enable
    logic cntEdge;     // counted event edge
    logic levelOk;     // input at measured level
    logic endEdge;     // edge closing the measured period
    logic tick;        // prescaler count enable
    always_comb begin
        case (sourceSelect)
            timer_pkg::SRC_F1:  srcTick = 1'b1;
            timer_pkg::SRC_F2:  srcTick = tickF2;
            timer_pkg::SRC_F8:  srcTick = tickF8;
            timer_pkg::SRC_OCO: srcTick = tickOco;
            timer_pkg::SRC_C32: srcTick = tickC32;
            default:            srcTick = 1'b0;
        endcase
    end
    assign cntEdge = edgeSeen(measPrev_q, measIn, polaritySelectBit);
    assign levelOk = polaritySelectBit ? ~measIn : measIn;
    assign endEdge = edgeSeen(measPrev_q, measIn, ~polaritySelectBit);
    // source tick per mode
    always_comb begin
        case (mode)
            timer_pkg::MODE_EVENT:       tick = running & cntEdge;
            timer_pkg::MODE_PULSE_WIDTH: tick = running & levelOk & srcTick;
            default:                     tick = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // prescaler
    logic [CNT_W-1:0] preReload_q;   // prescaler reload register
    logic [CNT_W-1:0] preCnt_q;      // prescaler counter
    logic             prePend_q;     // written value awaiting transfer
    logic [CNT_W:0]   preStep;
    logic             preUnder;
    assign preStep  = stepDown(preCnt_q, preReload_q);
    assign preUnder = tick & ~prePend_q & preStep[CNT_W];
    // reload register takes every write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            preReload_q <= timer_pkg::CNT_RESET;
        end else if (preWrite) begin
            preReload_q <= wrData;
        end
    end

    // prescaler counter and pending transfer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            preCnt_q  <= timer_pkg::CNT_RESET;
            prePend_q <= 1'b0;
        end else if (preWrite && !running) begin
            preCnt_q  <= wrData;
            prePend_q <= 1'b0;
        end else if (preWrite) begin
            prePend_q <= 1'b1;
            if (tick) begin
                preCnt_q <= preStep[CNT_W-1:0];
            end
        end else if (tick && prePend_q) begin
            preCnt_q  <= preReload_q;
            prePend_q <= 1'b0;
        end else if (tick) begin
            preCnt_q <= preStep[CNT_W-1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // timer
    logic [CNT_W-1:0] timReload_q;   // timer reload register
    logic [CNT_W-1:0] timCnt_q;      // timer counter
    logic             timPend_q;     // written value awaiting transfer
    logic [CNT_W:0]   timStep;
    logic             timUnder;
    assign timStep  = stepDown(timCnt_q, timReload_q);
    assign timUnder = preUnder & ~timPend_q & timStep[CNT_W];
    // reload register takes every write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timReload_q <= timer_pkg::CNT_RESET;
        end else if (timWrite) begin
            timReload_q <= wrData;
        end
    end

    // timer counter steps on prescaler underflow
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timCnt_q  <= timer_pkg::CNT_RESET;
            timPend_q <= 1'b0;
        end else if (timWrite && !running) begin
            timCnt_q  <= wrData;
            timPend_q <= 1'b0;
        end else if (timWrite) begin
            timPend_q <= 1'b1;
            if (preUnder) begin
                timCnt_q <= timStep[CNT_W-1:0];
            end
        end else if (preUnder && timPend_q) begin
            timCnt_q  <= timReload_q;
            timPend_q <= 1'b0;
        end else if (preUnder) begin
            timCnt_q <= timStep[CNT_W-1:0];
        end
    end
    assign prescalerCount = preCnt_q;
    assign timerCount     = timCnt_q;
    ////////////////////////////////////////////////////////////////////////
    // interrupt and inverted output
    // registered so the pulse is glitch free; one cycle late
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= timUnder |
                        (running && mode == timer_pkg::MODE_PULSE_WIDTH && endEdge);
        end
    end

    // inverted pulse output level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            invertedOut <= 1'b1;
        end else if (modeWrite) begin
            invertedOut <= ~polaritySelectBit;
        end else if (timUnder && invOutputEnableBit && mode == timer_pkg::MODE_EVENT) begin
            invertedOut <= ~invertedOut;
        end
    end

    // pin owned by timer only in event mode
    assign invertedOutTimer = invOutputEnableBit && (mode == timer_pkg::MODE_EVENT);
endmodule

// ### tb/timer_event_pw_sva.sv
// port-level assertions for the event / pulse width timer
module timer_event_pw_sva #(
    parameter int CNT_W = timer_pkg::CNT_W
) (
    // clock and reset
    input wire logic             sys_clk,
    input wire logic             reset,
    // control inputs
    input wire logic             startWrite,
    input wire logic             countStartBit,
    input wire logic             forcedStopBit,
    input wire logic             preWrite,
    input wire logic             timWrite,
    input wire logic [CNT_W-1:0] wrData,
    input wire logic             modeWrite,
    input wire logic             modeSelect,
    input wire logic             polaritySelectBit,
    input wire logic             invOutputEnableBit,
    // observed outputs
    input wire logic [CNT_W-1:0] prescalerCount,
    input wire logic [CNT_W-1:0] timerCount,
    input wire logic             countActive,
    input wire logic             timerIrq,
    input wire logic             invertedOut,
    input wire logic             invertedOutTimer
);
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    //////////////////////////////////////////
    a_start_runs: assert property (
        startWrite && countStartBit && !forcedStopBit |=> countActive) else $error("no start");
    a_stop_halts: assert property (
        startWrite && (!countStartBit || forcedStopBit) |=> !countActive) else $error("no stop");
    a_run_steady: assert property (
        !startWrite |=> $stable(countActive)) else $error("run state moved alone");
    a_stopped_preload: assert property (
        !countActive && !startWrite && preWrite |=> prescalerCount == $past(wrData))
        else $error("stopped prescaler write lost");
    a_stopped_timload: assert property (
        !countActive && !startWrite && timWrite |=> timerCount == $past(wrData))
        else $error("stopped timer write lost");
    a_stopped_frozen: assert property (
        !countActive && !startWrite && !preWrite && !timWrite
        |=> $stable(prescalerCount) && $stable(timerCount)) else $error("count while stopped");
    a_irq_running: assert property (
        timerIrq |-> $past(countActive)) else $error("irq while stopped");
    a_toggle_cause: assert property (
        $changed(invertedOut) && !$past(modeWrite) && !$past(reset)
        |-> timerIrq && $past(invertedOutTimer)) else $error("stray output toggle");
    a_irq_toggles: assert property (
        timerIrq && $past(invertedOutTimer) && !$past(modeWrite) |-> $changed(invertedOut))
        else $error("underflow without toggle");
    a_mode_level: assert property (
        modeWrite |=> invertedOut == !$past(polaritySelectBit)) else $error("bad start level");
    a_pin_owner: assert property (
        invertedOutTimer == (!modeSelect && invOutputEnableBit)) else $error("bad pin owner");
endmodule

bind timer_event_pw timer_event_pw_sva #(.CNT_W(CNT_W)) timer_event_pw_sva_inst (
    .sys_clk, .reset, .startWrite, .countStartBit, .forcedStopBit, .preWrite, .timWrite,
    .wrData, .modeWrite, .modeSelect, .polaritySelectBit, .invOutputEnableBit,
    .prescalerCount, .timerCount, .countActive, .timerIrq, .invertedOut, .invertedOutTimer);

// ### tb/signal_source.sv
// stand-in for the external signal feeding the timer input pins
module signal_source (
    // clock
    input  wire logic sys_clk,
    // which pin carries the measured signal
    input  wire logic pinSel,
    // candidate input pins
    output logic      ioPinA,
    output logic      ioPinB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic level = 1'b0; // measured signal
    logic noise = 1'b0; // junk on the unused pin
    // unused pin busy
    // toggles every cycle so a wrong route shows up at once
    always @(posedge sys_clk) begin
        noise <= ~noise;
    end
    assign ioPinA = pinSel ? noise : level;
    assign ioPinB = pinSel ? level : noise;
    // pulse train: high for hi cycles, then low for lo cycles
    task automatic pulses(input int cnt, input int hi, input int lo);
        @(posedge sys_clk);
        repeat (cnt) begin
            level <= 1'b1;
            repeat (hi) @(posedge sys_clk);
            level <= 1'b0;
            repeat (lo) @(posedge sys_clk);
        end
    endtask
endmodule

// ### tb/timer_event_and_pulse_width_tb.sv
// self-checking bench for the event / pulse width timer
module timer_event_and_pulse_width_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and design inputs
    logic       sys_clk = 1'b0, reset = 1'b1;
    logic       startWrite = 1'b0, countStartBit = 1'b0, forcedStopBit = 1'b0;
    logic       preWrite = 1'b0, timWrite = 1'b0, modeWrite = 1'b0;
    logic [7:0] wrData = 8'h00;
    logic       modeSelect = 1'b0, polaritySelectBit = 1'b0, inputPinSelectBit = 1'b0;
    logic       invOutputEnableBit = 1'b0, filterSelectBit0 = 1'b0, filterSelectBit1 = 1'b0;
    logic [2:0] sourceSelect = 3'h0;
    // slow clocks, run free from the bench clock below
    logic       onchipOscClock = 1'b0, subclockDiv32 = 1'b0;
    // design outputs and pins
    logic [7:0] prescalerCount, timerCount;
    logic       countActive, timerIrq, extIrqOne, invertedOut, invertedOutTimer;
    logic       ioPinA, ioPinB;
    // bookkeeping
    logic [7:0] irqCnt = 8'h00;
    int         n_errors = 0, n_tests = 0;
    //////////////////////////////////////////
    signal_source signal_source_inst (.sys_clk, .pinSel(inputPinSelectBit), .ioPinA, .ioPinB);
    timer_event_pw timer_event_pw_inst (.sys_clk, .reset, .ioPinA, .ioPinB, .onchipOscClock,
        .subclockDiv32, .startWrite, .countStartBit, .forcedStopBit, .preWrite, .timWrite,
        .wrData, .modeWrite, .modeSelect, .sourceSelect, .polaritySelectBit,
        .inputPinSelectBit, .invOutputEnableBit, .filterSelectBit0, .filterSelectBit1,
        .prescalerCount, .timerCount, .countActive, .timerIrq, .extIrqOne, .invertedOut,
        .invertedOutTimer);
    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;
    // oscillator at half and subclock at a quarter of the clock rate
    always @(posedge sys_clk) begin
        onchipOscClock <= ~onchipOscClock;
        if (onchipOscClock) begin
            subclockDiv32 <= ~subclockDiv32;
        end
    end
    // count interrupt pulses, one per cycle high
    always @(posedge sys_clk) begin
        if (timerIrq === 1'b1) begin
            irqCnt <= irqCnt + 8'h01;
        end
    end
    //////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic ctl(input logic s, input logic f);
        @(posedge sys_clk);
        startWrite <= 1'b1;
        countStartBit <= s;
        forcedStopBit <= f;
        @(posedge sys_clk);
        startWrite <= 1'b0;
    endtask
    // kind 0 mode write, 1 prescaler write, 2 timer write
    task automatic strobe(input int kind, input logic [7:0] d);
        @(posedge sys_clk);
        wrData <= d;
        modeWrite <= (kind == 0);
        preWrite <= (kind == 1);
        timWrite <= (kind == 2);
        @(posedge sys_clk);
        {modeWrite, preWrite, timWrite} <= 3'h0;
    endtask
    task automatic cfg(input logic md, input logic pol, input logic pin, input logic [1:0] flt,
                       input logic [2:0] src);
        @(posedge sys_clk);
        modeSelect <= md;
        polaritySelectBit <= pol;
        inputPinSelectBit <= pin;
        invOutputEnableBit <= 1'b1;
        {filterSelectBit1, filterSelectBit0} <= flt;
        sourceSelect <= src;
    endtask
    //////////////////////////////////////////
    task automatic test_reset();
        #1;
        check("pre rst", prescalerCount, 8'hFF);
        check("tim rst", timerCount, 8'hFF);
        check("run rst", {7'h00, countActive}, 8'h00);
    endtask
    task automatic test_event_ratio();
        logic [7:0] base;
        cfg(1'b0, 1'b1, 1'b0, timer_pkg::FILT_OFF, timer_pkg::SRC_F1);
        strobe(0, 8'h00);
        #1 check("start level", {7'h00, invertedOut}, 8'h00);
        cfg(1'b0, 1'b0, 1'b0, timer_pkg::FILT_OFF, timer_pkg::SRC_F1);
        strobe(1, 8'h02);
        strobe(2, 8'h01);
        #1 check("pre load", prescalerCount, 8'h02);
        check("tim load", timerCount, 8'h01);
        ctl(1'b1, 1'b0);
        #1 check("started", {7'h00, countActive}, 8'h01);
        base = irqCnt;
        signal_source_inst.pulses(18, 2, 2);
        tick(6);
        #1 check("irqs", irqCnt - base, 8'h03);
        check("toggled", {7'h00, invertedOut}, 8'h01);
        check("pin owner", {7'h00, invertedOutTimer}, 8'h01);
        check("pre reload", prescalerCount, 8'h02);
        check("tim reload", timerCount, 8'h01);
    endtask
    task automatic test_stop();
        ctl(1'b0, 1'b0);
        #1 check("stopped", {7'h00, countActive}, 8'h00);
        signal_source_inst.pulses(3, 2, 2);
        tick(4);
        #1 check("held", prescalerCount, 8'h02);
        ctl(1'b1, 1'b0);
        ctl(1'b1, 1'b1);
        #1 check("forced", {7'h00, countActive}, 8'h00);
        signal_source_inst.pulses(3, 2, 2);
        tick(4);
        #1 check("forced held", prescalerCount, 8'h02);
    endtask
    task automatic test_running_write();
        strobe(1, 8'h01);
        strobe(2, 8'h07);
        ctl(1'b1, 1'b0);
        strobe(2, 8'h04);
        #1 check("tim late", timerCount, 8'h07);
        signal_source_inst.pulses(2, 2, 2);
        tick(4);
        #1 check("tim moved", timerCount, 8'h04);
        strobe(1, 8'h03);
        #1 check("pre late", prescalerCount, 8'h01);
        signal_source_inst.pulses(1, 2, 2);
        tick(4);
        #1 check("pre moved", prescalerCount, 8'h03);
    endtask
    task automatic test_polarity_pin();
        ctl(1'b0, 1'b0);
        strobe(1, 8'h09);
        cfg(1'b0, 1'b1, 1'b1, timer_pkg::FILT_OFF, timer_pkg::SRC_F1);
        tick(6);
        ctl(1'b1, 1'b0);
        signal_source_inst.pulses(3, 2, 2);
        signal_source_inst.level <= 1'b1;
        tick(6);
        #1 check("falling only", prescalerCount, 8'h06);
    endtask
    task automatic test_filter();
        ctl(1'b0, 1'b0);
        signal_source_inst.level <= 1'b0;
        strobe(1, 8'h09);
        cfg(1'b0, 1'b0, 1'b1, timer_pkg::FILT_F1, timer_pkg::SRC_F1);
        tick(6);
        ctl(1'b1, 1'b0);
        signal_source_inst.pulses(1, 1, 6);
        signal_source_inst.pulses(1, 6, 6);
        #1 check("filtered", prescalerCount, 8'h08);
        cfg(1'b0, 1'b0, 1'b1, timer_pkg::FILT_OFF, timer_pkg::SRC_F1);
        signal_source_inst.pulses(1, 1, 4);
        #1 check("once", prescalerCount, 8'h07);
        // slow sampling: short pulse dropped, long pulse counted once
        cfg(1'b0, 1'b0, 1'b1, timer_pkg::FILT_F8, timer_pkg::SRC_F1);
        signal_source_inst.pulses(1, 6, 40);
        signal_source_inst.pulses(1, 40, 40);
        #1 check("slow filter", prescalerCount, 8'h06);
        cfg(1'b0, 1'b0, 1'b1, timer_pkg::FILT_F32, timer_pkg::SRC_F1);
        signal_source_inst.pulses(1, 20, 140);
        signal_source_inst.pulses(1, 140, 140);
        #1 check("slowest filter", prescalerCount, 8'h05);
    endtask
    task automatic test_width(input logic [2:0] src, input logic pol, input int w,
                              input logic [7:0] exp);
        logic [7:0] base;
        ctl(1'b0, 1'b0);
        strobe(1, 8'hFF);
        strobe(2, 8'hFF);
        cfg(1'b1, pol, 1'b1, timer_pkg::FILT_OFF, src);
        signal_source_inst.level <= pol;
        tick(6);
        ctl(1'b1, 1'b0);
        base = irqCnt;
        signal_source_inst.level <= ~pol;
        tick(w);
        signal_source_inst.level <= pol;
        tick(8);
        #1 check("width", 8'hFF - prescalerCount, exp);
        check("end irq", irqCnt - base, 8'h01);
        check("irq pin", {7'h00, extIrqOne}, {7'h00, pol});
        check("pin port", {7'h00, invertedOutTimer}, 8'h00);
    endtask
    //////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        tick(10);
        reset <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_event_ratio();
        test_stop();
        test_running_write();
        test_polarity_pin();
        test_filter();
        test_width(timer_pkg::SRC_F1, 1'b0, 16, 8'h10);
        test_width(timer_pkg::SRC_F2, 1'b0, 16, 8'h08);
        test_width(timer_pkg::SRC_F8, 1'b0, 16, 8'h02);
        test_width(timer_pkg::SRC_OCO, 1'b0, 16, 8'h08);
        test_width(timer_pkg::SRC_C32, 1'b0, 16, 8'h04);
        test_width(timer_pkg::SRC_F1, 1'b1, 5, 8'h05);
        finish_test();
    end
    // watchdog: the run needs about a thousand cycles, allow 20000
    initial begin
        #1_000_000;
        n_errors++;
        finish_test();
    end
endmodule
